//--- verilog/cvd_seq_defs.vh
// constants for the capacitive divider precharge and acquisition sequencer
`ifndef CVD_SEQ_DEFS_VH
`define CVD_SEQ_DEFS_VH
`define CVD_TIME_W       8
`define CVD_ACQ_MAX      9'h100
`define CVD_CONV_CYCLES  8'h0B
`define CVD_CLK_DIV      8'h04
`define CVD_ST_IDLE      3'h0
`define CVD_ST_PRE       3'h1
`define CVD_ST_ACQ       3'h2
`define CVD_ST_CONV      3'h3
`define CVD_ST_SWACQ     3'h4
`endif

//--- verilog/cvd_seq.v
// precharge, acquisition and conversion hand-off sequencer for capacitive sensing
// Functional notes
// (RULE_01) nonzero precharge time enables precharge
// (RULE_02) precharge starts on any conversion start
// (RULE_03) zero precharge time skips precharge
// (RULE_04) precharge opens outer sample path
// (RULE_05) hold cap tied per polarity
// (RULE_06) pin drives opposite level during precharge
// (RULE_07) precharge length from precharge time
// (RULE_08) precharge drive overrides pin direction
// (RULE_09) precharge end: bias off, path reconnected
// (RULE_10) acquisition length from acquisition time
// (RULE_11) no precharge: acquire at conversion start
// (RULE_12) precharge: acquire right after precharge
// (RULE_13) acquisition releases pin output drivers
// (RULE_14) acquisition connects channel to hold cap
// (RULE_15) zero acquisition with precharge means 256
// (RULE_16) zero acquisition without precharge: software timed
// (RULE_17) convert held voltage after acquisition
// (RULE_18) differential repeats sequence with inverted levels
// (RULE_19) software waits acquisition after channel change
// (RULE_20) done clears go unless continuous, flags
// (RULE_21) timers count converter clocks, load per stage
`include "cvd_seq_defs.vh"

module cvd_seq #(
  parameter TIME_W      = `CVD_TIME_W,
  parameter [7:0] CLK_DIV    = `CVD_CLK_DIV,
  parameter [7:0] CONV_CYCLES = `CVD_CONV_CYCLES
) (
  // clock and reset
  input  wire              CLOCK_I,
  input  wire              RSTN_I,
  // control
  input  wire              ENABLE_I,
  input  wire              GO_SET_I,
  input  wire              GO_CLEAR_I,
  input  wire              TRIGGER_I,
  input  wire              RESTART_I,
  input  wire              CONTINUOUS_CONVERSION_I,
  input  wire              DOUBLE_SAMPLE_I,
  input  wire              FLAG_CLEAR_I,
  // timing and polarity
  input  wire [TIME_W-1:0] PRECHARGE_TIME_COUNT_I,
  input  wire [TIME_W-1:0] ACQUISITION_TIME_COUNT_I,
  input  wire              PRECHARGE_POLARITY_I,
  // status
  output reg               CONVERSION_GO_O,
  output reg               CONVERSION_DONE_FLAG_O,
  output reg               SECOND_SAMPLE_O,
  output reg  [2:0]        STAGE_O,
  // analog switch controls
  output reg               OUTER_PATH_CONNECT_O,
  output reg               HOLD_TO_SUPPLY_O,
  output reg               HOLD_TO_GROUND_O,
  output reg               CHANNEL_CONNECT_O,
  output reg               CONVERT_O,
  output reg               SAMPLE_DONE_O,
  // pin override
  output reg               PIN_OVERRIDE_O,
  output reg               PIN_DRIVE_EN_O,
  output reg               PIN_DRIVE_LEVEL_O
);

  reg [2:0]        state_q;
  reg [2:0]        state_d;
  reg [8:0]        timer_q;
  reg [8:0]        timer_d;
  reg [7:0]        div_q;
  reg              go_q;
  reg              go_d;
  reg              flag_q;
  reg              second_q;
  reg              second_d;
  reg              done_pulse;
  reg              pol_q;
  reg              pol_d;
  reg              tick;
  wire             start;
  wire             pre_en;
  wire             acq_en;
  wire             abort;
  // next values of the registered outputs
  reg              flag_d;
  reg              outer_d;
  reg              hold_sup_d;
  reg              hold_gnd_d;
  reg              chan_d;
  reg              conv_d;
  reg              ovr_d;
  reg              drv_en_d;
  reg              drv_lvl_d;

  assign pre_en = |PRECHARGE_TIME_COUNT_I; // RULE_01
  assign start  = ENABLE_I & (state_q == `CVD_ST_IDLE)
                & (GO_SET_I | TRIGGER_I | RESTART_I | go_q); // RULE_02
  assign acq_en = |ACQUISITION_TIME_COUNT_I;
  assign abort  = GO_CLEAR_I | ~ENABLE_I;

  // converter clock enable
  always @(posedge CLOCK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      div_q <= 8'h00;
    else if (div_q >= CLK_DIV - 8'h01)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end

  always @*
  begin
    tick = (div_q == 8'h00); // RULE_21
  end

  // stage sequencing
  always @*
  begin
    state_d    = state_q;
    timer_d    = timer_q;
    go_d       = go_q;
    second_d   = second_q;
    pol_d      = pol_q;
    done_pulse = 1'b0;
    if (GO_SET_I | TRIGGER_I | RESTART_I)
      go_d = 1'b1;
    case (state_q)
      `CVD_ST_IDLE:
      begin
        if (start)
        begin
          go_d     = 1'b1;
          second_d = 1'b0;
          pol_d    = PRECHARGE_POLARITY_I;
          if (pre_en)
          begin
            state_d = `CVD_ST_PRE; // RULE_02
            timer_d = {1'b0, PRECHARGE_TIME_COUNT_I}; // RULE_07
          end
          else if (|ACQUISITION_TIME_COUNT_I)
          begin
            state_d = `CVD_ST_ACQ; // RULE_03 RULE_11
            timer_d = {1'b0, ACQUISITION_TIME_COUNT_I}; // RULE_10
          end
          else
          begin
            state_d = `CVD_ST_CONV; // RULE_16
            timer_d = {1'b0, CONV_CYCLES};
          end
        end
      end
      `CVD_ST_PRE:
      begin
        if (tick)
        begin
          if (timer_q <= 9'h001)
          begin
            state_d = `CVD_ST_ACQ; // RULE_09 RULE_12
            timer_d = (|ACQUISITION_TIME_COUNT_I) ?
                      {1'b0, ACQUISITION_TIME_COUNT_I} : `CVD_ACQ_MAX; // RULE_15
          end
          else
            timer_d = timer_q - 9'h001; // RULE_21
        end
      end
      `CVD_ST_ACQ:
      begin
        if (tick)
        begin
          if (timer_q <= 9'h001)
          begin
            state_d = `CVD_ST_CONV; // RULE_17
            timer_d = {1'b0, CONV_CYCLES};
          end
          else
            timer_d = timer_q - 9'h001;
        end
      end
      `CVD_ST_CONV:
      begin
        if (tick)
        begin
          if (timer_q <= 9'h001)
          begin
            done_pulse = 1'b1;
            if (DOUBLE_SAMPLE_I & ~second_q)
            begin
              second_d = 1'b1;
              pol_d    = ~pol_q; // RULE_18
              if (pre_en)
              begin
                state_d = `CVD_ST_PRE;
                timer_d = {1'b0, PRECHARGE_TIME_COUNT_I};
              end
              else if (acq_en)
              begin
                state_d = `CVD_ST_ACQ;
                timer_d = {1'b0, ACQUISITION_TIME_COUNT_I};
              end
              else
              begin
                // no timed acquisition in the second sample either
                state_d = `CVD_ST_CONV; // RULE_16
                timer_d = {1'b0, CONV_CYCLES};
              end
            end
            else
            begin
              state_d = `CVD_ST_IDLE;
              go_d    = CONTINUOUS_CONVERSION_I; // RULE_20
            end
          end
          else
            timer_d = timer_q - 9'h001;
        end
      end
      default:
      begin
        state_d = `CVD_ST_IDLE;
      end
    endcase
    // software abort discards the sequence
    if (abort)
    begin
      go_d    = 1'b0;
      state_d = `CVD_ST_IDLE;
    end
  end

  always @(posedge CLOCK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      state_q  <= `CVD_ST_IDLE;
      timer_q  <= 9'h000;
      go_q     <= 1'b0;
      flag_q   <= 1'b0;
      second_q <= 1'b0;
      pol_q    <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      timer_q  <= timer_d;
      go_q     <= go_d;
      second_q <= second_d;
      pol_q    <= pol_d;
      flag_q   <= flag_d;
    end
  end

  // done flag: a completion wins over a clear in the same cycle
  always @*
  begin
    flag_d = flag_q;
    if (FLAG_CLEAR_I)
      flag_d = 1'b0;
    if (done_pulse)
      flag_d = 1'b1; // RULE_20
  end

  // next values of the switch and pin controls
  always @*
  begin
    outer_d    = 1'b1;
    hold_sup_d = 1'b0;
    hold_gnd_d = 1'b0;
    chan_d     = 1'b0;
    conv_d     = 1'b0;
    ovr_d      = 1'b0;
    drv_en_d   = 1'b0;
    drv_lvl_d  = 1'b0;
    case (state_d)
      `CVD_ST_IDLE:
      begin
        // channel rests on the hold cap between conversions
        chan_d = 1'b1;
      end
      `CVD_ST_PRE:
      begin
        // hold cap isolated and biased, pin driven the other way
        outer_d    = 1'b0; // RULE_04
        hold_sup_d = pol_d; // RULE_05
        hold_gnd_d = ~pol_d; // RULE_05
        ovr_d      = 1'b1; // RULE_08
        drv_en_d   = 1'b1; // RULE_06
        drv_lvl_d  = ~pol_d; // RULE_06
      end
      `CVD_ST_ACQ:
      begin
        // bias off, path closed, pin drivers released
        chan_d = 1'b1; // RULE_09 RULE_14
        ovr_d  = 1'b1; // RULE_13
      end
      `CVD_ST_CONV:
      begin
        conv_d = 1'b1; // RULE_17
      end
      default:
      begin
        outer_d = 1'b1;
      end
    endcase
  end

  // registered outputs from next-state values
  always @(posedge CLOCK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      CONVERSION_GO_O        <= 1'b0;
      CONVERSION_DONE_FLAG_O <= 1'b0;
      SECOND_SAMPLE_O        <= 1'b0;
      STAGE_O                <= `CVD_ST_IDLE;
      OUTER_PATH_CONNECT_O   <= 1'b1;
      HOLD_TO_SUPPLY_O       <= 1'b0;
      HOLD_TO_GROUND_O       <= 1'b0;
      CHANNEL_CONNECT_O      <= 1'b0;
      CONVERT_O              <= 1'b0;
      SAMPLE_DONE_O          <= 1'b0;
      PIN_OVERRIDE_O         <= 1'b0;
      PIN_DRIVE_EN_O         <= 1'b0;
      PIN_DRIVE_LEVEL_O      <= 1'b0;
    end
    else
    begin
      CONVERSION_GO_O        <= go_d;
      CONVERSION_DONE_FLAG_O <= flag_d;
      SECOND_SAMPLE_O        <= second_d;
      STAGE_O                <= state_d;
      SAMPLE_DONE_O          <= done_pulse;
      OUTER_PATH_CONNECT_O   <= outer_d;
      HOLD_TO_SUPPLY_O       <= hold_sup_d;
      HOLD_TO_GROUND_O       <= hold_gnd_d;
      CHANNEL_CONNECT_O      <= chan_d;
      CONVERT_O              <= conv_d;
      PIN_OVERRIDE_O         <= ovr_d;
      PIN_DRIVE_EN_O         <= drv_en_d;
      PIN_DRIVE_LEVEL_O      <= drv_lvl_d;
    end
  end

endmodule // cvd_seq

//--- test/cvd_sensor_model.sv
// capacitive sensor node on the overridden analog pin
module cvd_sensor_model (
  // pin side
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic override_i,
  input  wire logic drive_en_i,
  input  wire logic drive_level_i,
  // charge level of the sensor node
  output logic      node_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // only device on the pin: charged while driven, keeps charge after
  always @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
      node_o <= 1'b0;
    else if (override_i && drive_en_i)
      node_o <= drive_level_i;
endmodule // cvd_sensor_model

//--- test/cvd_seq_monitor.sv
// assertion checker for the capacitive divider sequencer
module cvd_seq_monitor #(
  parameter       TIME_W      = 8,
  parameter [7:0] CLK_DIV     = 8'h04,
  parameter [7:0] CONV_CYCLES = 8'h0B
) (
  // clock, reset and control
  input wire logic              CLOCK_I,
  input wire logic              RSTN_I,
  input wire logic              ENABLE_I,
  input wire logic              GO_SET_I,
  input wire logic              GO_CLEAR_I,
  input wire logic [TIME_W-1:0] PRECHARGE_TIME_COUNT_I,
  input wire logic [TIME_W-1:0] ACQUISITION_TIME_COUNT_I,
  // status and switches
  input wire logic              CONVERSION_DONE_FLAG_O,
  input wire logic [2:0]        STAGE_O,
  input wire logic              OUTER_PATH_CONNECT_O,
  input wire logic              HOLD_TO_SUPPLY_O,
  input wire logic              HOLD_TO_GROUND_O,
  input wire logic              CHANNEL_CONNECT_O,
  input wire logic              CONVERT_O,
  input wire logic              SAMPLE_DONE_O,
  input wire logic              PIN_OVERRIDE_O,
  input wire logic              PIN_DRIVE_EN_O,
  input wire logic              PIN_DRIVE_LEVEL_O
);
  localparam int DV = CLK_DIV;
  localparam int CE = DV * CONV_CYCLES;
  int          pe;
  int          ae;
  logic [2:0]  prv_q;
  logic [11:0] cyc_q;
  assign pe = DV * PRECHARGE_TIME_COUNT_I;
  assign ae = DV * (ACQUISITION_TIME_COUNT_I == 0 ? 256 : ACQUISITION_TIME_COUNT_I);
  // length of the current run of one stage value or one conversion
  always @(posedge CLOCK_I or negedge RSTN_I)
    if (!RSTN_I)
    begin
      prv_q <= 3'h0;
      cyc_q <= 12'h000;
    end
    else
    begin
      prv_q <= STAGE_O;
      cyc_q <= (STAGE_O == prv_q && !SAMPLE_DONE_O) ? cyc_q + 12'h001 : 12'h001;
    end
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);
  start_stage_a: assert property (STAGE_O == 3'h0 && GO_SET_I && ENABLE_I && !GO_CLEAR_I
    |=> STAGE_O == (PRECHARGE_TIME_COUNT_I != 0 ? 3'h1 : ACQUISITION_TIME_COUNT_I != 0 ? 3'h2 : 3'h3))
    else $error("wrong first stage");
  pre_switches_a: assert property (STAGE_O == 3'h1
    |-> !OUTER_PATH_CONNECT_O && PIN_OVERRIDE_O && PIN_DRIVE_EN_O) else $error("precharge switches");
  pre_bias_a: assert property (STAGE_O == 3'h1 |-> HOLD_TO_SUPPLY_O != HOLD_TO_GROUND_O)
    else $error("hold bias");
  pin_opposite_a: assert property (STAGE_O == 3'h1 |-> PIN_DRIVE_LEVEL_O == HOLD_TO_GROUND_O)
    else $error("pin level");
  pre_exit_a: assert property (STAGE_O == 3'h1 && ENABLE_I && !GO_CLEAR_I ##1 STAGE_O != 3'h1
    |-> STAGE_O == 3'h2) else $error("precharge exit");
  acq_release_a: assert property (STAGE_O == 3'h2 |-> OUTER_PATH_CONNECT_O && CHANNEL_CONNECT_O
    && !PIN_DRIVE_EN_O && !HOLD_TO_SUPPLY_O && !HOLD_TO_GROUND_O) else $error("acquire switches");
  pre_len_a: assert property (STAGE_O == 3'h2 && prv_q == 3'h1
    |-> cyc_q <= pe && cyc_q + DV > pe) else $error("precharge length");
  acq_len_a: assert property (STAGE_O == 3'h3 && prv_q == 3'h2 && PRECHARGE_TIME_COUNT_I != 0
    |-> cyc_q <= ae && cyc_q + DV > ae) else $error("acquire length");
  done_flag_a: assert property (SAMPLE_DONE_O |-> CONVERSION_DONE_FLAG_O && $past(CONVERT_O))
    else $error("done flag");
  conv_len_a: assert property (SAMPLE_DONE_O |-> prv_q == 3'h3
    && cyc_q <= CE && cyc_q + DV > CE) else $error("conversion length");
  cover property (prv_q == 3'h1 && STAGE_O == 3'h2);
  cover property (prv_q == 3'h0 && STAGE_O == 3'h3);
  cover property (prv_q == 3'h2 && STAGE_O == 3'h3 && cyc_q > 12'h03F0);
endmodule // cvd_seq_monitor

bind cvd_seq cvd_seq_monitor #(.TIME_W(TIME_W), .CLK_DIV(CLK_DIV), .CONV_CYCLES(CONV_CYCLES))
  i_mon (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .ENABLE_I(ENABLE_I), .GO_SET_I(GO_SET_I),
    .GO_CLEAR_I(GO_CLEAR_I), .PRECHARGE_TIME_COUNT_I(PRECHARGE_TIME_COUNT_I),
    .ACQUISITION_TIME_COUNT_I(ACQUISITION_TIME_COUNT_I),
    .CONVERSION_DONE_FLAG_O(CONVERSION_DONE_FLAG_O), .STAGE_O(STAGE_O),
    .OUTER_PATH_CONNECT_O(OUTER_PATH_CONNECT_O), .HOLD_TO_SUPPLY_O(HOLD_TO_SUPPLY_O),
    .HOLD_TO_GROUND_O(HOLD_TO_GROUND_O), .CHANNEL_CONNECT_O(CHANNEL_CONNECT_O),
    .CONVERT_O(CONVERT_O), .SAMPLE_DONE_O(SAMPLE_DONE_O), .PIN_OVERRIDE_O(PIN_OVERRIDE_O),
    .PIN_DRIVE_EN_O(PIN_DRIVE_EN_O), .PIN_DRIVE_LEVEL_O(PIN_DRIVE_LEVEL_O));

//--- test/testbench.sv
// self-checking bench for the capacitive divider sequencer
`include "cvd_seq_defs.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DV = `CVD_CLK_DIV;
  logic       clk = 0, rstn = 0, en = 1, go = 0, gclr = 0, trg = 0, rsq = 0;
  logic       cont = 0, dbl = 0, fclr = 0, pol = 0;
  logic [7:0] pre = 0, acq = 0;
  wire        go_o, flag, sec, outer, hs, hg, chan, cvt, done, ovr, den, dlv, node;
  wire  [2:0] stg;
  int         failures = 0, checks = 0, pn, an, dn;
  always #5 clk = ~clk;
  cvd_seq i_dut (.CLOCK_I(clk), .RSTN_I(rstn), .ENABLE_I(en), .GO_SET_I(go), .GO_CLEAR_I(gclr),
    .TRIGGER_I(trg), .RESTART_I(rsq), .CONTINUOUS_CONVERSION_I(cont), .DOUBLE_SAMPLE_I(dbl),
    .FLAG_CLEAR_I(fclr), .PRECHARGE_TIME_COUNT_I(pre), .ACQUISITION_TIME_COUNT_I(acq),
    .PRECHARGE_POLARITY_I(pol), .CONVERSION_GO_O(go_o), .CONVERSION_DONE_FLAG_O(flag),
    .SECOND_SAMPLE_O(sec), .STAGE_O(stg), .OUTER_PATH_CONNECT_O(outer), .HOLD_TO_SUPPLY_O(hs),
    .HOLD_TO_GROUND_O(hg), .CHANNEL_CONNECT_O(chan), .CONVERT_O(cvt), .SAMPLE_DONE_O(done),
    .PIN_OVERRIDE_O(ovr), .PIN_DRIVE_EN_O(den), .PIN_DRIVE_LEVEL_O(dlv));
  cvd_sensor_model i_sensor (.clk_i(clk), .rstn_i(rstn), .override_i(ovr), .drive_en_i(den),
    .drive_level_i(dlv), .node_o(node));
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // start by go, trigger or restart, then count stage cycles until idle
  task automatic run(input logic [7:0] p, a, input logic pl, db, input int k);
    int ea, m;
    ea = (a != 0) ? a : (p != 0 ? 256 : 0);
    m = db + 1;
    @(negedge clk);
    {pre, acq, pol, dbl} = {p, a, pl, db};
    {go, trg, rsq} = 3'h1 << (2 - k);
    @(negedge clk);
    {go, trg, rsq} = 3'h0;
    {pn, an, dn} = 0;
    for (int i = 0; i < 3000 && !(stg === 3'h0 && go_o === 1'b0); i++)
    begin
      pn += (stg === 3'h1);
      an += (stg === 3'h2);
      dn += (done === 1'b1);
      @(negedge clk);
    end
    dn += (done === 1'b1);
    `CHK({stg, go_o}, 4'h0)
    `CHK(sec, db)
    `CHK(pn <= DV * p * m && pn + DV * m > DV * p * m, 1'b1)
    `CHK(an <= DV * ea * m && an + DV * m > DV * ea * m, 1'b1)
    `CHK(dn, m)
    `CHK(flag, 1'b1)
    if (p != 0)
      `CHK(node, pl ^ ~db)
    fclr = 1;
    @(negedge clk);
    fclr = 0;
    `CHK(flag, 1'b0)
    $display("test %0d pre %0d acq %0d ended", k, p, a);
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    rstn = 1;
    run(8'h02, 8'h03, 1'b0, 1'b0, 0);
    run(8'h01, 8'h00, 1'b1, 1'b0, 1);
    run(8'h00, 8'h05, 1'b0, 1'b0, 2);
    run(8'h00, 8'h00, 1'b1, 1'b0, 0);
    run(8'h03, 8'h02, 1'b1, 1'b1, 0);
    run(8'h00, 8'h00, 1'b0, 1'b1, 1);
    // continuous: conversions follow back to back until go is cleared
    @(negedge clk);
    {pre, acq, dbl, cont, go} = {8'h01, 8'h01, 1'b0, 1'b1, 1'b1};
    @(negedge clk);
    go = 0;
    dn = 0;
    for (int i = 0; i < 400 && dn < 2; i++)
    begin
      @(negedge clk);
      dn += (done === 1'b1);
    end
    `CHK(dn, 2)
    `CHK(go_o, 1'b1)
    {gclr, cont} = 2'h2;
    @(negedge clk);
    gclr = 0;
    `CHK({stg, go_o}, 4'h0)
    $display("test continuous ended");
    tally_and_finish;
  end
  initial
  begin
    #100us;
    failures++;
    $display("[ERR] %0t watchdog", $time);
    tally_and_finish;
  end
endmodule // testbench
